// >>> core/fs_supervisor_pkg.sv
// Constants for the format sequencer supervisory block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package fs_supervisor_pkg;

    localparam int AXI_ADDR_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_BUF_CONFIG = 8'h53;
    localparam logic [7:0] IDX_SYNC_LIMIT = 8'h70;
    localparam logic [7:0] IDX_SEQ_START = 8'h79;
    localparam logic [7:0] IDX_ERR_STATUS = 8'h7A;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h7B;
    localparam logic [7:0] IDX_SYNC_PATTERN = 8'h7C;

    localparam logic [9:0] ADDR_BUF_CONFIG = {IDX_BUF_CONFIG, 2'h0};
    localparam logic [9:0] ADDR_SYNC_LIMIT = {IDX_SYNC_LIMIT, 2'h0};
    localparam logic [9:0] ADDR_SEQ_START = {IDX_SEQ_START, 2'h0};
    localparam logic [9:0] ADDR_ERR_STATUS = {IDX_ERR_STATUS, 2'h0};
    localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};
    localparam logic [9:0] ADDR_SYNC_PATTERN = {IDX_SYNC_PATTERN, 2'h0};

    // Field positions
    localparam int STAT_SYNC_TIMEOUT_BIT = 4;
    localparam int STAT_TWO_INDEX_BIT = 5;
    localparam int STAT_PARITY_BIT = 6;
    localparam logic [7:0] STAT_IMPL_MASK = 8'h70;
    localparam int COUNT_SYNC_START_BIT = 5;
    localparam int CTRL_DATA_XFER_BIT = 0;
    localparam int BUFCFG_PARITY_EN_BIT = 3;

    localparam logic [4:0] SEQ_STOP_ADDR = 5'h1F;

    // Reset values
    localparam logic [7:0] SYNC_LIMIT_RST = 8'h00;
    localparam logic [7:0] SYNC_PATTERN_RST = 8'h00;
    localparam logic [7:0] BUF_CONFIG_RST = 8'h00;
    localparam logic [7:0] ERR_STATUS_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [4:0] SEQ_START_RST = 5'h1F;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'h0,
        SEQ_RUN = 1'h1
    } seq_state_t;

endpackage : fs_supervisor_pkg

// >>> core/byte_parity_check.sv
// Odd parity checker for buffer bytes at the formatter serdes.
// Assumes data and parity arrive on sys_clk with a qualifying strobe.
`timescale 1ns/10ps
module byte_parity_check
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic checkEn,
    input wire logic [7:0] dataByte,
    input wire logic parityBit,
    output logic errPulse
);

    typedef struct packed {
        logic err;
    } par_state_t;

    par_state_t s;
    par_state_t n;

    always_comb
    begin
        n = s;
        // Odd parity: nine bits together carry an odd number of ones
        n.err = checkEn && !(^{dataByte, parityBit});
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign errPulse = s.err;

endmodule : byte_parity_check

// >>> core/format_supervisor.sv
// Supervisory circuits of the format sequencer: sync timer,
// two-index revolution limiter, buffer parity check, AXI4-Lite registers.
// Assumes sequencer strobes and byte ticks are synchronous to sys_clk;
// only the index pin is asynchronous.
//
// Function
// - Hold one 8-bit software sync byte-count limit, 0 to 255.
// - Sync timer bounds time spent matching the programmed sync pattern.
// - Active timer loads from limit and decrements once per byte time.
// - Count reaching zero: time-out, halt sequencer, set status bit 4.
// - Instruction with count field bit 5 set starts the sync timer.
// - Sequencer reset or detected sync character clears the sync timer.
// - Same count field bit 5 turns on the revolution limiter.
// - Active limiter: second index rising edge halts, sets status bit 5.
// - Limiter resets while sequencer stopped or on data transfer instruction.
// - Check buffer parity during NRZ writes and sector data verify reads.
// - Parity enabled and error seen sets status bit 6.
// - Parity branch command halts the sequencer after a parity error.
// - Fetch of address 1FH, or start write of 1FH, stops sequencer.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
module format_supervisor
    import fs_supervisor_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic byteTick,
    input wire logic instrValid,
    input wire logic [7:0] instrCount,
    input wire logic [7:0] instrControl,
    input wire logic parityBranch,
    input wire logic fetchValid,
    input wire logic [4:0] fetchAddr,
    input wire logic [7:0] nrzByte,
    input wire logic nrzByteValid,
    input wire logic indexPin,
    input wire logic nrzWrite,
    input wire logic verifyRead,
    input wire logic [7:0] bufByte,
    input wire logic bufParity,
    input wire logic bufByteValid,
    output logic seqStart,
    output logic [4:0] seqStartAddr,
    output logic seqRunning,
    output logic seqHalt,
    output logic syncTimerActive,
    output logic irq
);

    typedef struct packed {
        seq_state_t seq;
        logic [4:0] startAddr;
        logic startPulse;
        logic haltPulse;
        logic [7:0] syncLimit;
        logic [7:0] syncPattern;
        logic [7:0] bufConfig;
        logic [7:0] status;
        logic [7:0] mask;
        logic syncActive;
        logic [7:0] syncCount;
        logic idxActive;
        logic idxSeen;
        logic [1:0] idxSync;
        logic idxPrev;
        logic irq;
        logic awHeld;
        logic [AXI_ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [7:0] wData;
        logic wStrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;

    localparam state_t STATE_RST = '{
        seq: SEQ_IDLE, startAddr: SEQ_START_RST,
        syncLimit: SYNC_LIMIT_RST, syncPattern: SYNC_PATTERN_RST,
        bufConfig: BUF_CONFIG_RST, status: ERR_STATUS_RST,
        mask: IRQ_MASK_RST, default: '0};

    state_t s;
    state_t n;

    logic parErr;
    logic wrEn;
    logic startWr;
    logic statusWr;
    logic syncFound;
    logic syncLoad;
    logic syncExpire;
    logic idxEdge;
    logic fetchStop;
    logic branchStop;
    logic [7:0] setBits;

    function automatic logic isMapped(input logic [AXI_ADDR_W-1:0] a);
        return a == ADDR_BUF_CONFIG || a == ADDR_SYNC_LIMIT ||
            a == ADDR_SEQ_START || a == ADDR_ERR_STATUS ||
            a == ADDR_IRQ_MASK || a == ADDR_SYNC_PATTERN;
    endfunction : isMapped

    function automatic logic [31:0] regRead(input logic [AXI_ADDR_W-1:0] a,
        input state_t st);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_BUF_CONFIG: v = st.bufConfig;
            ADDR_SYNC_LIMIT: v = st.syncLimit;
            ADDR_SEQ_START: v = {3'h0, st.startAddr};
            ADDR_ERR_STATUS: v = st.status;
            ADDR_IRQ_MASK: v = st.mask;
            ADDR_SYNC_PATTERN: v = st.syncPattern;
            default: v = 8'h00;
        endcase
        return {24'h000000, v};
    endfunction : regRead

    // Only NRZ writes and verify reads see buffer parity
    byte_parity_check parityCheck (
        .sys_clk(sys_clk),
        .rst(rst),
        .checkEn(bufByteValid && (nrzWrite || verifyRead)),
        .dataByte(bufByte),
        .parityBit(bufParity),
        .errPulse(parErr)
    );

    assign wrEn = s.awHeld && s.wHeld && !s.bvalid;
    assign startWr = wrEn && s.wStrb0 && s.awAddr == ADDR_SEQ_START;
    assign statusWr = wrEn && s.wStrb0 && s.awAddr == ADDR_ERR_STATUS;
    assign syncFound = nrzByteValid && nrzByte == s.syncPattern;
    assign syncLoad = instrValid && instrCount[COUNT_SYNC_START_BIT] &&
        s.seq == SEQ_RUN;
    // Limit 0 and 1 both expire at the first byte time
    assign syncExpire = s.syncActive && byteTick &&
        s.syncCount <= 8'h01;
    assign idxEdge = s.idxSync[1] && !s.idxPrev;
    assign fetchStop = fetchValid && fetchAddr == SEQ_STOP_ADDR;
    assign branchStop = instrValid && parityBranch &&
        (s.status[STAT_PARITY_BIT] || setBits[STAT_PARITY_BIT]);

    always_comb
    begin
        n = s;
        setBits = 8'h00;
        n.startPulse = 1'b0;
        n.haltPulse = 1'b0;

        // Index pin: two-stage synchroniser, then edge detect
        n.idxSync = {s.idxSync[0], indexPin};
        n.idxPrev = s.idxSync[1];

        // Sync timer
        if (s.syncActive && byteTick)
        begin
            if (syncExpire)
            begin
                setBits[STAT_SYNC_TIMEOUT_BIT] = 1'b1;
                n.syncActive = 1'b0;
                n.syncCount = 8'h00;
            end
            else
            begin
                n.syncCount = s.syncCount - 8'h01;
            end
        end
        if (syncLoad)
        begin
            n.syncActive = 1'b1;
            n.syncCount = s.syncLimit;
        end
        // Detection wins over a load in the same cycle
        if (syncFound || s.seq == SEQ_IDLE)
        begin
            n.syncActive = 1'b0;
            n.syncCount = 8'h00;
        end

        // Two-index revolution limiter
        if (s.idxActive && idxEdge)
        begin
            if (s.idxSeen)
            begin
                setBits[STAT_TWO_INDEX_BIT] = 1'b1;
            end
            else
            begin
                n.idxSeen = 1'b1;
            end
        end
        if (syncLoad)
        begin
            n.idxActive = 1'b1;
        end
        if (s.seq == SEQ_IDLE ||
            (instrValid && instrControl[CTRL_DATA_XFER_BIT]))
        begin
            n.idxActive = 1'b0;
            n.idxSeen = 1'b0;
        end

        if (parErr && s.bufConfig[BUFCFG_PARITY_EN_BIT])
        begin
            setBits[STAT_PARITY_BIT] = 1'b1;
        end

        // Halt sources
        if (s.seq == SEQ_RUN && (setBits[STAT_SYNC_TIMEOUT_BIT] ||
            setBits[STAT_TWO_INDEX_BIT] || fetchStop || branchStop))
        begin
            n.seq = SEQ_IDLE;
            n.haltPulse = 1'b1;
        end

        // AXI4-Lite write: address and data taken in either order
        if (s_axi_awvalid && s.awready)
        begin
            n.awHeld = 1'b1;
            n.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready)
        begin
            n.wHeld = 1'b1;
            n.wData = s_axi_wdata[7:0];
            n.wStrb0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        if (wrEn)
        begin
            n.awHeld = 1'b0;
            n.wHeld = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = isMapped(s.awAddr) ? RESP_OKAY : RESP_SLVERR;
            if (s.wStrb0)
            begin
                case (s.awAddr)
                    ADDR_BUF_CONFIG: n.bufConfig = s.wData;
                    ADDR_SYNC_LIMIT: n.syncLimit = s.wData;
                    ADDR_IRQ_MASK: n.mask = s.wData & STAT_IMPL_MASK;
                    ADDR_SYNC_PATTERN: n.syncPattern = s.wData;
                    default: n.mask = n.mask;
                endcase
            end
        end
        // A new start address overrides a halt in the same cycle
        if (startWr)
        begin
            n.startAddr = s.wData[4:0];
            n.startPulse = 1'b1;
            n.seq = s.wData[4:0] == SEQ_STOP_ADDR ? SEQ_IDLE : SEQ_RUN;
        end

        // Sticky flags; a new event beats a write-one clear
        n.status = (s.status & ~(statusWr ? s.wData : 8'h00)) |
            setBits;
        n.irq = |(n.status & n.mask);

        // AXI4-Lite read
        if (s.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready)
        begin
            n.rvalid = 1'b1;
            n.rdata = regRead(s_axi_araddr, s);
            n.rresp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        n.awready = !n.awHeld && !n.bvalid;
        n.wready = !n.wHeld && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s <= STATE_RST;
        end
        else
        begin
            s <= n;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign seqStart = s.startPulse;
    assign seqStartAddr = s.startAddr;
    assign seqRunning = s.seq == SEQ_RUN;
    assign seqHalt = s.haltPulse;
    assign syncTimerActive = s.syncActive;
    assign irq = s.irq;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence haltSeen;
        seqHalt && !seqRunning;
    endsequence

    sequence secondIndex;
        s.idxActive && s.idxSeen && idxEdge;
    endsequence

    AST_SYNC_LOAD: assert property (
        syncLoad && !syncFound |=> s.syncActive &&
            s.syncCount == $past(s.syncLimit))
        else $error("sync timer did not load from the limit");

    AST_SYNC_DEC: assert property (
        s.syncActive && byteTick && !syncExpire && !syncLoad &&
            !syncFound && s.seq == SEQ_RUN
        |=> s.syncCount == $past(s.syncCount) - 8'h01)
        else $error("sync count did not step down by one");

    AST_SYNC_TIMEOUT: assert property (
        syncExpire && !startWr && s.seq == SEQ_RUN
        |=> haltSeen ##0 s.status[STAT_SYNC_TIMEOUT_BIT])
        else $error("sync time-out did not halt and flag");

    AST_SYNC_FOUND: assert property (
        syncFound |=> !s.syncActive)
        else $error("sync detect did not clear the timer");

    AST_TWO_INDEX: assert property (
        secondIndex and (s.seq == SEQ_RUN && !startWr)
        |=> haltSeen ##0 s.status[STAT_TWO_INDEX_BIT])
        else $error("second index did not halt and flag");

    AST_LIMITER_RESET: assert property (
        s.seq == SEQ_IDLE || (instrValid && instrControl[CTRL_DATA_XFER_BIT])
        |=> !s.idxActive && !s.idxSeen)
        else $error("revolution limiter not reset");

    AST_PARITY_FLAG: assert property (
        parErr && s.bufConfig[BUFCFG_PARITY_EN_BIT]
        |=> s.status[STAT_PARITY_BIT])
        else $error("parity error not flagged");

    AST_PARITY_BRANCH: assert property (
        instrValid && parityBranch && s.status[STAT_PARITY_BIT] &&
            s.seq == SEQ_RUN && !startWr |=> haltSeen)
        else $error("parity branch did not halt");

    AST_STOP_FETCH: assert property (
        fetchStop && s.seq == SEQ_RUN && !startWr |=> !seqRunning)
        else $error("stop address fetch did not stop");

    AST_STICKY: assert property (
        s.status[STAT_SYNC_TIMEOUT_BIT] && !statusWr
        |=> s.status[STAT_SYNC_TIMEOUT_BIT] [*1])
        else $error("time-out flag dropped without a clear");

    AST_IRQ_LEVEL: assert property (
        irq == |(s.status & s.mask))
        else $error("interrupt level disagrees with status and mask");

endmodule : format_supervisor

// >>> test/drive_model.sv
// Drive-side model: byte-time strobes, NRZ read bytes and index pulse.
// Assumes its tasks are called right after a rising sys_clk edge.
`timescale 1ns/10ps
module drive_model
(
    input wire logic sys_clk,
    output logic byteTick,
    output logic [7:0] nrzByte,
    output logic nrzByteValid,
    output logic indexPin
);
    initial
    begin
        byteTick = 1'b0;
        nrzByte = 8'hFF;
        nrzByteValid = 1'b0;
        indexPin = 1'b0;
    end

    // Gap makes slow byte times; idle data is the inverted last byte
    task automatic send_byte(input logic [7:0] val, input int gap);
        byteTick <= 1'b1;
        nrzByteValid <= 1'b1;
        nrzByte <= val;
        @(posedge sys_clk);
        byteTick <= 1'b0;
        nrzByteValid <= 1'b0;
        nrzByte <= ~val;
        repeat (gap + 1) @(posedge sys_clk);
    endtask : send_byte

    // Index edges land off the clock phase, as a real spindle would
    task automatic index_pulse();
        #3 indexPin = 1'b1;
        repeat (6) @(posedge sys_clk);
        #3 indexPin = 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask : index_pulse
endmodule : drive_model

// >>> test/format_supervisor_tb.sv
// Self-checking bench for format_supervisor over AXI4-Lite.
// Assumes the drive model supplies byte times, NRZ bytes and index.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module format_supervisor_tb;
    import fs_supervisor_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1;
    logic [9:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp;
    logic instrValid = 0, parityBranch = 0, fetchValid = 0;
    logic [7:0] instrCount = '0, instrControl = '0, bufByte = '0;
    logic [4:0] fetchAddr = '0;
    logic nrzWrite = 0, verifyRead = 0, bufParity = 0, bufByteValid = 0;
    logic byteTick, nrzByteValid, indexPin;
    logic [7:0] nrzByte;
    logic seqStart, seqRunning, seqHalt, syncTimerActive, irq;
    logic [4:0] seqStartAddr;
    int error_cnt = 0, check_count = 0, haltCnt = 0, startCnt = 0;

    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        if (seqHalt === 1'b1) haltCnt <= haltCnt + 1;
        if (seqStart === 1'b1) startCnt <= startCnt + 1;
    end

    format_supervisor format_supervisor_i (.sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .byteTick(byteTick), .instrValid(instrValid),
        .instrCount(instrCount), .instrControl(instrControl),
        .parityBranch(parityBranch), .fetchValid(fetchValid),
        .fetchAddr(fetchAddr), .nrzByte(nrzByte),
        .nrzByteValid(nrzByteValid), .indexPin(indexPin),
        .nrzWrite(nrzWrite), .verifyRead(verifyRead), .bufByte(bufByte),
        .bufParity(bufParity), .bufByteValid(bufByteValid),
        .seqStart(seqStart), .seqStartAddr(seqStartAddr),
        .seqRunning(seqRunning), .seqHalt(seqHalt),
        .syncTimerActive(syncTimerActive), .irq(irq));

    drive_model drive_model_i (.sys_clk(sys_clk), .byteTick(byteTick),
        .nrzByte(nrzByte), .nrzByteValid(nrzByteValid), .indexPin(indexPin));

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    task automatic wr(input logic [9:0] a, input logic [7:0] d,
        input logic [1:0] er);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        `CHK(bresp, er)
        bready <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        `CHK(rresp, er)
        if (er == RESP_OKAY) `CHK(rdata, ed)
        rready <= 1'b0;
        @(posedge sys_clk);
    endtask : rd

    task automatic instr(input logic [7:0] c, input logic [7:0] k,
        input logic pb);
        instrValid <= 1'b1;
        instrCount <= c;
        instrControl <= k;
        parityBranch <= pb;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        parityBranch <= 1'b0;
        @(posedge sys_clk);
    endtask : instr

    task automatic buf_byte(input logic [7:0] b, input logic p);
        bufByte <= b;
        bufParity <= p;
        bufByteValid <= 1'b1;
        @(posedge sys_clk);
        bufByteValid <= 1'b0;
        tick(4);
    endtask : buf_byte

    task automatic tally_and_finish();
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        tick(20000);
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        int h;
        tick(4);
        rst <= 1'b0;
        tick(2);
        `CHK(seqStartAddr, SEQ_START_RST)
        rd(ADDR_SYNC_LIMIT, 32'h0, RESP_OKAY);
        rd(ADDR_SYNC_PATTERN, 32'h0, RESP_OKAY);
        rd(ADDR_ERR_STATUS, 32'h0, RESP_OKAY);
        rd(10'h000, 32'h0, RESP_SLVERR);
        wr(10'h004, 8'h11, RESP_SLVERR);
        wr(ADDR_SYNC_LIMIT, 8'hFF, RESP_OKAY);
        rd(ADDR_SYNC_LIMIT, 32'hFF, RESP_OKAY);
        // Limit 2: second byte time must time out, not the first
        wr(ADDR_SYNC_LIMIT, 8'h02, RESP_OKAY);
        wr(ADDR_SEQ_START, 8'h01, RESP_OKAY);
        tick(1);
        `CHK(startCnt, 1)
        `CHK(seqRunning, 1'b1)
        h = haltCnt;
        instr(8'h20, 8'h00, 1'b0);
        `CHK(syncTimerActive, 1'b1)
        drive_model_i.send_byte(8'h3C, 3);
        `CHK(haltCnt, h)
        drive_model_i.send_byte(8'h3C, 0);
        tick(2);
        `CHK(haltCnt, h + 1)
        `CHK(seqRunning, 1'b0)
        `CHK(irq, 1'b0)
        wr(ADDR_IRQ_MASK, 8'h70, RESP_OKAY);
        tick(2);
        `CHK(irq, 1'b1)
        tick(20);
        rd(ADDR_ERR_STATUS, 32'h10, RESP_OKAY);
        wr(ADDR_ERR_STATUS, 8'h10, RESP_OKAY);
        tick(2);
        `CHK(irq, 1'b0)
        rd(ADDR_ERR_STATUS, 32'h0, RESP_OKAY);
        // Limit 0 times out at the first byte time
        wr(ADDR_SYNC_LIMIT, 8'h00, RESP_OKAY);
        wr(ADDR_SEQ_START, 8'h02, RESP_OKAY);
        instr(8'h20, 8'h00, 1'b0);
        drive_model_i.send_byte(8'h3C, 0);
        tick(2);
        `CHK(haltCnt, h + 2)
        wr(ADDR_ERR_STATUS, 8'h10, RESP_OKAY);
        // Sync character found clears the timer before it expires
        wr(ADDR_SYNC_PATTERN, 8'hA5, RESP_OKAY);
        wr(ADDR_SYNC_LIMIT, 8'h03, RESP_OKAY);
        wr(ADDR_SEQ_START, 8'h03, RESP_OKAY);
        instr(8'h20, 8'h00, 1'b0);
        drive_model_i.send_byte(8'hA5, 1);
        `CHK(syncTimerActive, 1'b0)
        repeat (4) drive_model_i.send_byte(8'h3C, 0);
        `CHK(haltCnt, h + 2)
        fetchAddr <= SEQ_STOP_ADDR;
        fetchValid <= 1'b1;
        tick(1);
        fetchValid <= 1'b0;
        tick(2);
        `CHK(seqRunning, 1'b0)
        `CHK(haltCnt, h + 3)
        // Second index edge halts an armed limiter
        wr(ADDR_SEQ_START, 8'h04, RESP_OKAY);
        instr(8'h20, 8'h00, 1'b0);
        drive_model_i.index_pulse();
        `CHK(haltCnt, h + 3)
        drive_model_i.index_pulse();
        `CHK(haltCnt, h + 4)
        rd(ADDR_ERR_STATUS, 32'h20, RESP_OKAY);
        wr(ADDR_ERR_STATUS, 8'h20, RESP_OKAY);
        // Data transfer bit and stopping both disarm the limiter
        wr(ADDR_SEQ_START, 8'h05, RESP_OKAY);
        instr(8'h20, 8'h01, 1'b0);
        repeat (2) drive_model_i.index_pulse();
        `CHK(haltCnt, h + 4)
        instr(8'h20, 8'h00, 1'b0);
        drive_model_i.index_pulse();
        wr(ADDR_SEQ_START, 8'h1F, RESP_OKAY);
        `CHK(seqRunning, 1'b0)
        wr(ADDR_SEQ_START, 8'h06, RESP_OKAY);
        repeat (2) drive_model_i.index_pulse();
        `CHK(haltCnt, h + 4)
        // Parity: odd over nine bits, only in write or verify
        nrzWrite <= 1'b1;
        buf_byte(8'h01, 1'b1);
        rd(ADDR_ERR_STATUS, 32'h0, RESP_OKAY);
        wr(ADDR_BUF_CONFIG, 8'h08, RESP_OKAY);
        buf_byte(8'h01, 1'b0);
        rd(ADDR_ERR_STATUS, 32'h0, RESP_OKAY);
        buf_byte(8'h01, 1'b1);
        rd(ADDR_ERR_STATUS, 32'h40, RESP_OKAY);
        instr(8'h00, 8'h00, 1'b1);
        tick(2);
        `CHK(haltCnt, h + 5)
        wr(ADDR_ERR_STATUS, 8'h40, RESP_OKAY);
        nrzWrite <= 1'b0;
        verifyRead <= 1'b1;
        buf_byte(8'h03, 1'b0);
        rd(ADDR_ERR_STATUS, 32'h40, RESP_OKAY);
        wr(ADDR_ERR_STATUS, 8'h40, RESP_OKAY);
        verifyRead <= 1'b0;
        buf_byte(8'h03, 1'b0);
        rd(ADDR_ERR_STATUS, 32'h0, RESP_OKAY);
        tally_and_finish();
    end
endmodule : format_supervisor_tb
